// file: afs_params.svh
// Register indices, field positions, reset values and limits of the analog frequency reference scaler
`ifndef AFS_PARAMS_SVH
`define AFS_PARAMS_SVH

`define AFS_IDX_SRC        4'h0
`define AFS_IDX_BASE1      4'h1
`define AFS_IDX_MAX1       4'h2
`define AFS_IDX_BASE2      4'h3
`define AFS_IDX_MAX2       4'h4
`define AFS_IDX_VFS        4'h5
`define AFS_IDX_VFE        4'h6
`define AFS_IDX_VPCT       4'h7
`define AFS_IDX_CFS        4'h8
`define AFS_IDX_CFE        4'h9
`define AFS_IDX_CPCT       4'hA
`define AFS_IDX_STAT       4'hB

`define AFS_SRC_INSEL_LSB  8
`define AFS_SRC_VBELOW_LSB 12
`define AFS_SRC_CBELOW_LSB 16
`define AFS_SRC_AVG_LSB    24
`define AFS_PCT_END_LSB    8

`define AFS_RST_SRC        8'h01
`define AFS_RST_INSEL      2'h0
`define AFS_RST_BELOW      2'h1
`define AFS_RST_AVG        4'h2
`define AFS_RST_BASE       12'h01F4
`define AFS_RST_MAX        12'h01F4
`define AFS_RST_FREQ       12'h0000
`define AFS_RST_PCT_START  7'h00
`define AFS_RST_PCT_END    7'h64

`define AFS_SRC_TERMINAL   8'h01
`define AFS_BELOW_START    2'h0
`define AFS_BELOW_ZERO     2'h1
`define AFS_BASE_MIN       12'h012C
`define AFS_FREQ_LIMIT     12'h0FA0
`define AFS_PCT_LIMIT      7'h64
`define AFS_FULL_VOLT      10'h03E8
`define AFS_FULL_SAMPLE    10'h03E8
`define AFS_AVG_MAX        4'h8
`define AFS_DIV_STEPS      5'h15

`endif

// file: afs_pkg.sv
// Types shared by the analog frequency reference scaler
package afs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PREP_A = 3'b001,
    ST_DIV_A  = 3'b011,
    ST_PREP_B = 3'b010,
    ST_DIV_B  = 3'b110,
    ST_PREP_V = 3'b111,
    ST_DIV_V  = 3'b101,
    ST_FINISH = 3'b100
  } state_t;

  typedef logic [7:0][9:0] hist_t;
endpackage

// file: analog_frequency_reference_scaler.sv
// Sample FIFO and analog speed reference to frequency and voltage command scaler
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`include "afs_params.svh"

module sample_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_arst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_reg;
  wire              push = i_in_valid && ready_reg;
  wire              pop  = o_out_valid && i_out_ready;

  assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign o_in_ready  = ready_reg;
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      ready_reg  <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_next;
      ready_reg  <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule

// Function
// - Set-1 base frequency write taken only from 30 Hz up to set-1 maximum.
// - Set-1 maximum frequency write taken only from set-1 base up to 400 Hz.
// - Set-2 base and maximum frequency obey the same limits against each other.
// - Voltage rises with frequency to full scale at base, then stays full.
// - Output is built from one selected motor set only, never mixed.
// - Voltage channel maps start-to-end percent linearly onto start-to-end frequency.
// - Voltage input above end percent gives exactly the end frequency.
// - Voltage input below start gives start frequency for code 00, zero for 01.
// - Current channel maps its own span onto its own frequency range.
// - Current input above its end point gives its end frequency.
// - Current input below start gives zero or start frequency by its option.
// - Start and end frequencies 0.0 to 400.0 in tenths, reset 0.0.
// - Start and end percentages 0 to 100, reset 0 and 100.
// - Input select codes: selector V/I, V+I sum, V/pot, I/pot.
// - Reference averaged over the latest n samples, n from 1 to 8.
// - Analog result used only for terminal source code 01 or forced terminal.
module analog_frequency_reference_scaler
  import afs_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_sample_valid,
  output logic             o_sample_ready,
  input  wire logic [9:0]  i_volt_sample,
  input  wire logic [9:0]  i_curr_sample,
  input  wire logic [9:0]  i_pot_sample,
  input  wire logic        i_input_selector_terminal,
  input  wire logic        i_terminal_force,
  input  wire logic        i_set2_select,
  input  wire logic [11:0] i_other_freq,
  output logic [11:0]      o_freq_cmd,
  output logic [9:0]       o_volt_cmd,
  output logic             o_freq_valid,
  output logic             o_motor_set,
  output logic             o_ref_is_analog
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  function automatic logic [9:0] pct10(input logic [6:0] p);
    pct10 = {3'b000, p} * 10'd10;
  endfunction

  function automatic logic [11:0] sat_freq(input logic [12:0] f);
    sat_freq = (f > {1'b0, `AFS_FREQ_LIMIT}) ? `AFS_FREQ_LIMIT : f[11:0];
  endfunction

  function automatic logic [9:0] clip_sample(input logic [9:0] s);
    clip_sample = (s > `AFS_FULL_SAMPLE) ? `AFS_FULL_SAMPLE : s;
  endfunction

  function automatic logic [9:0] avg_n(input hist_t h, input logic [3:0] n);
    logic [12:0] s;
    logic [16:0] r;
    logic [29:0] p;
    s = '0;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        s = s + {3'b000, h[i]};
      end
    end
    case (n)
      4'h1:    r = 17'h1_0000;
      4'h2:    r = 17'h0_8000;
      4'h3:    r = 17'h0_5556;
      4'h4:    r = 17'h0_4000;
      4'h5:    r = 17'h0_3334;
      4'h6:    r = 17'h0_2AAB;
      4'h7:    r = 17'h0_2493;
      default: r = 17'h0_2000;
    endcase
    p = {17'b0, s} * {13'b0, r};
    avg_n = p[25:16];
  endfunction

  // Register file
  logic [7:0]  src_reg;
  logic [1:0]  insel_reg, vbelow_reg, cbelow_reg;
  logic [3:0]  avg_reg;
  logic [11:0] base1_reg, max1_reg, base2_reg, max2_reg;
  logic [11:0] vfs_reg, vfe_reg, cfs_reg, cfe_reg;
  logic [6:0]  vps_reg, vpe_reg, cps_reg, cpe_reg;
  logic [31:0] readdata_reg;
  logic        waitreq_reg;
  state_t      state_reg, state_next;

  wire [31:0] src_word = {4'h0, avg_reg, 6'h00, cbelow_reg, 2'h0, vbelow_reg, 2'h0, insel_reg, src_reg};
  wire [31:0] rd_word =
    (i_avs_address == `AFS_IDX_SRC)   ? src_word :
    (i_avs_address == `AFS_IDX_BASE1) ? {20'h0_0000, base1_reg} :
    (i_avs_address == `AFS_IDX_MAX1)  ? {20'h0_0000, max1_reg} :
    (i_avs_address == `AFS_IDX_BASE2) ? {20'h0_0000, base2_reg} :
    (i_avs_address == `AFS_IDX_MAX2)  ? {20'h0_0000, max2_reg} :
    (i_avs_address == `AFS_IDX_VFS)   ? {20'h0_0000, vfs_reg} :
    (i_avs_address == `AFS_IDX_VFE)   ? {20'h0_0000, vfe_reg} :
    (i_avs_address == `AFS_IDX_VPCT)  ? {17'h0_0000, vpe_reg, 1'b0, vps_reg} :
    (i_avs_address == `AFS_IDX_CFS)   ? {20'h0_0000, cfs_reg} :
    (i_avs_address == `AFS_IDX_CFE)   ? {20'h0_0000, cfe_reg} :
    (i_avs_address == `AFS_IDX_CPCT)  ? {17'h0_0000, cpe_reg, 1'b0, cps_reg} :
    (i_avs_address == `AFS_IDX_STAT)  ? {1'b0, state_reg, 2'h0, o_ref_is_analog, o_motor_set, 2'h0,
                                         o_volt_cmd, o_freq_cmd} :
    32'h0000_0000;

  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wd      = (rd_word & ~be_mask) | (i_avs_writedata & be_mask);
  wire        wr_en   = i_avs_write && !waitreq_reg;
  wire [11:0] wf      = wd[11:0];
  wire [6:0]  w_ps    = wd[6:0];
  wire [6:0]  w_pe    = wd[`AFS_PCT_END_LSB +: 7];
  wire [7:0]  w_src   = wd[7:0];
  wire [1:0]  w_insel = wd[`AFS_SRC_INSEL_LSB +: 2];
  wire [1:0]  w_vbel  = wd[`AFS_SRC_VBELOW_LSB +: 2];
  wire [1:0]  w_cbel  = wd[`AFS_SRC_CBELOW_LSB +: 2];
  wire [3:0]  w_avg   = wd[`AFS_SRC_AVG_LSB +: 4];

  wire base1_ok = (wf >= `AFS_BASE_MIN) && (wf <= max1_reg);
  wire max1_ok  = (wf >= base1_reg) && (wf <= `AFS_FREQ_LIMIT);
  wire base2_ok = (wf >= `AFS_BASE_MIN) && (wf <= max2_reg);
  wire max2_ok  = (wf >= base2_reg) && (wf <= `AFS_FREQ_LIMIT);
  wire freq_ok  = (wf <= `AFS_FREQ_LIMIT);
  wire ps_ok    = (w_ps <= `AFS_PCT_LIMIT);
  wire pe_ok    = (w_pe <= `AFS_PCT_LIMIT);
  wire src_ok   = (w_src <= 8'h03) || (w_src == 8'h10);
  wire avg_ok   = (w_avg != 4'h0) && (w_avg <= `AFS_AVG_MAX);

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      waitreq_reg  <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else begin
      waitreq_reg  <= !(waitreq_reg && (i_avs_read || i_avs_write));
      if (waitreq_reg && i_avs_read) begin
        readdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      src_reg    <= `AFS_RST_SRC;
      insel_reg  <= `AFS_RST_INSEL;
      vbelow_reg <= `AFS_RST_BELOW;
      cbelow_reg <= `AFS_RST_BELOW;
      avg_reg    <= `AFS_RST_AVG;
      base1_reg  <= `AFS_RST_BASE;
      max1_reg   <= `AFS_RST_MAX;
      base2_reg  <= `AFS_RST_BASE;
      max2_reg   <= `AFS_RST_MAX;
      vfs_reg    <= `AFS_RST_FREQ;
      vfe_reg    <= `AFS_RST_FREQ;
      cfs_reg    <= `AFS_RST_FREQ;
      cfe_reg    <= `AFS_RST_FREQ;
      vps_reg    <= `AFS_RST_PCT_START;
      vpe_reg    <= `AFS_RST_PCT_END;
      cps_reg    <= `AFS_RST_PCT_START;
      cpe_reg    <= `AFS_RST_PCT_END;
    end else if (wr_en) begin
      if (i_avs_address == `AFS_IDX_SRC) begin
        src_reg    <= src_ok ? w_src : src_reg;
        insel_reg  <= w_insel;
        vbelow_reg <= (w_vbel <= `AFS_BELOW_ZERO) ? w_vbel : vbelow_reg;
        cbelow_reg <= (w_cbel <= `AFS_BELOW_ZERO) ? w_cbel : cbelow_reg;
        avg_reg    <= avg_ok ? w_avg : avg_reg;
      end else if (i_avs_address == `AFS_IDX_BASE1 && base1_ok) begin
        base1_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_MAX1 && max1_ok) begin
        max1_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_BASE2 && base2_ok) begin
        base2_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_MAX2 && max2_ok) begin
        max2_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_VFS && freq_ok) begin
        vfs_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_VFE && freq_ok) begin
        vfe_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_CFS && freq_ok) begin
        cfs_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_CFE && freq_ok) begin
        cfe_reg <= wf;
      end else if (i_avs_address == `AFS_IDX_VPCT) begin
        // Each percentage field is checked on its own
        vps_reg <= ps_ok ? w_ps : vps_reg;
        vpe_reg <= pe_ok ? w_pe : vpe_reg;
      end else if (i_avs_address == `AFS_IDX_CPCT) begin
        cps_reg <= ps_ok ? w_ps : cps_reg;
        cpe_reg <= pe_ok ? w_pe : cpe_reg;
      end
    end
  end

  assign o_avs_readdata    = readdata_reg;
  assign o_avs_waitrequest = waitreq_reg;

  // Sample path: FIFO, input selection, averaging
  logic        fifo_valid;
  logic [29:0] fifo_data;
  wire         pop = fifo_valid && (state_reg == ST_IDLE);

  sample_fifo #(.WIDTH(30), .DEPTH(16)) sample_fifo_inst (
    .i_clk_sys   (i_clk_sys),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (o_sample_ready),
    .i_in_data   ({i_pot_sample, i_curr_sample, i_volt_sample}),
    .o_out_valid (fifo_valid),
    .i_out_ready (state_reg == ST_IDLE),
    .o_out_data  (fifo_data)
  );

  hist_t hist_a_reg, hist_b_reg;
  logic  sel_reg;
  wire   use_pot = i_input_selector_terminal && insel_reg[1];
  wire [9:0] a_in = clip_sample(use_pot ? fifo_data[29:20] : fifo_data[9:0]);
  wire [9:0] b_in = clip_sample(fifo_data[19:10]);
  wire [9:0] avg_a = avg_n(hist_a_reg, avg_reg);
  wire [9:0] avg_b = avg_n(hist_b_reg, avg_reg);

  // Segment mapping for the channel being worked on
  wire        chan_b = (state_reg == ST_PREP_B) || (state_reg == ST_DIV_B);
  wire [9:0]  seg_x  = chan_b ? avg_b : avg_a;
  wire [9:0]  seg_xs = pct10(chan_b ? cps_reg : vps_reg);
  wire [9:0]  seg_xe = pct10(chan_b ? cpe_reg : vpe_reg);
  wire [11:0] seg_fs = chan_b ? cfs_reg : vfs_reg;
  wire [11:0] seg_fe = chan_b ? cfe_reg : vfe_reg;
  wire [1:0]  seg_bm = chan_b ? cbelow_reg : vbelow_reg;
  wire        seg_below = seg_x < seg_xs;
  wire        seg_above = !seg_below && (seg_x >= seg_xe);
  wire        seg_down  = seg_fe < seg_fs;
  wire [11:0] seg_df    = seg_down ? (seg_fs - seg_fe) : (seg_fe - seg_fs);
  wire [9:0]  seg_dx    = seg_x - seg_xs;
  wire [21:0] seg_num   = {10'h000, seg_df} * {12'h000, seg_dx};
  wire [11:0] seg_direct = seg_above ? seg_fe : ((seg_bm == `AFS_BELOW_ZERO) ? 12'h000 : seg_fs);

  // Shared restoring divider
  logic [21:0] num_reg, num_next, quo_reg, quo_next;
  logic [11:0] den_reg, den_next, rem_reg, rem_next;
  logic [4:0]  cnt_reg, cnt_next;
  wire  [12:0] rem_sh  = {rem_reg, num_reg[21]};
  wire         div_ge  = rem_sh >= {1'b0, den_reg};
  wire  [12:0] rem_sub = rem_sh - {1'b0, den_reg};
  wire  [21:0] quo_new = {quo_reg[20:0], div_ge};
  wire  [12:0] seg_up  = {1'b0, seg_fs} + {1'b0, quo_new[11:0]};
  wire  [11:0] seg_fin = seg_down ? ((quo_new[11:0] > seg_fs) ? 12'h000 : seg_fs - quo_new[11:0])
                                  : sat_freq(seg_up);

  // Channel combination, source choice, motor set limits
  logic [11:0] res_a_reg, res_a_next, res_b_reg, res_b_next, fin_f_reg, fin_f_next;
  logic [9:0]  fin_v_reg, fin_v_next;
  logic        set_reg, set_next, an_reg, an_next;
  wire  [11:0] f_an =
    (insel_reg == 2'h0) ? (sel_reg ? res_b_reg : res_a_reg) :
    (insel_reg == 2'h1) ? sat_freq({1'b0, res_a_reg} + {1'b0, res_b_reg}) :
    (insel_reg == 2'h2) ? res_a_reg :
    (sel_reg ? res_a_reg : res_b_reg);
  wire        an_sel = (src_reg == `AFS_SRC_TERMINAL) || i_terminal_force;
  wire [11:0] f_ref  = an_sel ? f_an : sat_freq({1'b0, i_other_freq});
  wire [11:0] base_u = i_set2_select ? base2_reg : base1_reg;
  wire [11:0] max_u  = i_set2_select ? max2_reg : max1_reg;
  wire [11:0] f_lim  = (f_ref > max_u) ? max_u : f_ref;

  always_comb begin
    state_next = state_reg;
    num_next   = num_reg;
    den_next   = den_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    cnt_next   = cnt_reg;
    res_a_next = res_a_reg;
    res_b_next = res_b_reg;
    fin_f_next = fin_f_reg;
    fin_v_next = fin_v_reg;
    set_next   = set_reg;
    an_next    = an_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pop) begin
          state_next = ST_PREP_A;
        end
      end
      ST_PREP_A, ST_PREP_B: begin
        if (seg_below || seg_above) begin
          res_a_next = chan_b ? res_a_reg : seg_direct;
          res_b_next = chan_b ? seg_direct : res_b_reg;
          state_next = chan_b ? ST_PREP_V : ST_PREP_B;
        end else begin
          num_next   = seg_num;
          den_next   = {2'b00, seg_xe - seg_xs};
          rem_next   = '0;
          quo_next   = '0;
          cnt_next   = `AFS_DIV_STEPS;
          state_next = chan_b ? ST_DIV_B : ST_DIV_A;
        end
      end
      ST_DIV_A, ST_DIV_B, ST_DIV_V: begin
        num_next = {num_reg[20:0], 1'b0};
        rem_next = div_ge ? rem_sub[11:0] : rem_sh[11:0];
        quo_next = quo_new;
        cnt_next = cnt_reg - 5'd1;
        if (cnt_reg == 5'd0) begin
          if (state_reg == ST_DIV_A) begin
            res_a_next = seg_fin;
            state_next = ST_PREP_B;
          end else if (state_reg == ST_DIV_B) begin
            res_b_next = seg_fin;
            state_next = ST_PREP_V;
          end else begin
            fin_v_next = quo_new[9:0];
            state_next = ST_FINISH;
          end
        end
      end
      ST_PREP_V: begin
        fin_f_next = f_lim;
        set_next   = i_set2_select;
        an_next    = an_sel;
        if (f_lim >= base_u) begin
          fin_v_next = `AFS_FULL_VOLT;
          state_next = ST_FINISH;
        end else begin
          num_next   = {10'h000, f_lim} * {12'h000, `AFS_FULL_VOLT};
          den_next   = base_u;
          rem_next   = '0;
          quo_next   = '0;
          cnt_next   = `AFS_DIV_STEPS;
          state_next = ST_DIV_V;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_IDLE;
      {num_reg, quo_reg, den_reg, rem_reg, cnt_reg} <= '0;
      {res_a_reg, res_b_reg, fin_f_reg, fin_v_reg, set_reg, an_reg} <= '0;
      {hist_a_reg, hist_b_reg, sel_reg} <= '0;
    end else begin
      state_reg <= state_next;
      {num_reg, quo_reg, den_reg, rem_reg, cnt_reg} <= {num_next, quo_next, den_next, rem_next, cnt_next};
      {res_a_reg, res_b_reg, fin_f_reg, fin_v_reg} <= {res_a_next, res_b_next, fin_f_next, fin_v_next};
      {set_reg, an_reg} <= {set_next, an_next};
      if (pop) begin
        hist_a_reg <= {hist_a_reg[6:0], a_in};
        hist_b_reg <= {hist_b_reg[6:0], b_in};
        sel_reg    <= i_input_selector_terminal;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_freq_cmd      <= 12'h000;
      o_volt_cmd      <= 10'h000;
      o_freq_valid    <= 1'b0;
      o_motor_set     <= 1'b0;
      o_ref_is_analog <= 1'b0;
    end else begin
      o_freq_valid <= (state_reg == ST_FINISH);
      if (state_reg == ST_FINISH) begin
        o_freq_cmd      <= fin_f_reg;
        o_volt_cmd      <= fin_v_reg;
        o_motor_set     <= set_reg;
        o_ref_is_analog <= an_reg;
      end
    end
  end

  sequence s_pop;
    pop;
  endsequence

  sequence s_result;
    ##[1:90] o_freq_valid;
  endsequence

  property p_base1_range;
    (base1_reg >= `AFS_BASE_MIN) && (base1_reg <= max1_reg);
  endproperty
  a_base1_range: assert property (p_base1_range) else $error("set 1 base out of range");

  property p_max1_range;
    wr_en && (i_avs_address == `AFS_IDX_MAX1) && (wf > `AFS_FREQ_LIMIT) |=> $stable(max1_reg);
  endproperty
  a_max1_range: assert property (p_max1_range) else $error("set 1 maximum took an illegal value");

  property p_set2_range;
    (base2_reg >= `AFS_BASE_MIN) && (base2_reg <= max2_reg) && (max2_reg <= `AFS_FREQ_LIMIT);
  endproperty
  a_set2_range: assert property (p_set2_range) else $error("set 2 limits violated");

  property p_volt_curve;
    o_freq_valid |-> ((o_volt_cmd == `AFS_FULL_VOLT) ||
                      (o_freq_cmd < (o_motor_set ? base2_reg : base1_reg)));
  endproperty
  a_volt_curve: assert property (p_volt_curve) else $error("voltage not full above base");

  property p_set_max;
    o_freq_valid |-> (o_freq_cmd <= (o_motor_set ? max2_reg : max1_reg));
  endproperty
  a_set_max: assert property (p_set_max) else $error("frequency above selected set maximum");

  property p_above_end;
    (state_reg == ST_PREP_A) && seg_above |=> (res_a_reg == $past(vfe_reg)) && (state_reg == ST_PREP_B);
  endproperty
  a_above_end: assert property (p_above_end) else $error("above end did not give end frequency");

  property p_below_zero;
    (state_reg == ST_PREP_A) && seg_below && (vbelow_reg == `AFS_BELOW_ZERO) |=> (res_a_reg == 12'h000);
  endproperty
  a_below_zero: assert property (p_below_zero) else $error("below start did not give zero");

  property p_curr_below;
    (state_reg == ST_PREP_B) && seg_below && (cbelow_reg == `AFS_BELOW_START) |=> (res_b_reg == $past(cfs_reg));
  endproperty
  a_curr_below: assert property (p_curr_below) else $error("current below start wrong");

  property p_avg_range;
    (avg_reg != 4'h0) && (avg_reg <= `AFS_AVG_MAX);
  endproperty
  a_avg_range: assert property (p_avg_range) else $error("average count out of range");

  property p_source;
    o_freq_valid && !o_ref_is_analog |-> $past(src_reg, 2) != `AFS_SRC_TERMINAL || 1'b1 == $past(i_terminal_force, 2);
  endproperty
  a_source: assert property (p_source) else $error("analog source flag inconsistent");

  property p_recompute;
    s_pop |-> s_result;
  endproperty
  a_recompute: assert property (p_recompute) else $error("no result after new sample");
endmodule

// file: sample_source.sv
// Digitiser model offering sample triples on a valid/ready stream
`timescale 1ns/1ns
module sample_source (
  input  wire logic i_clk_sys,
  input  wire logic i_sample_ready,
  output logic       o_sample_valid,
  output logic [9:0] o_volt,
  output logic [9:0] o_curr,
  output logic [9:0] o_pot
);
  initial begin
    o_sample_valid = 1'b0;
    {o_volt, o_curr, o_pot} = '0;
  end
  // Idle lines show inverted data so stale values never pass
  task automatic send(input logic [9:0] v, input logic [9:0] c, input logic [9:0] p, input int gap);
    repeat (gap) @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    o_sample_valid <= 1'b1;
    {o_volt, o_curr, o_pot} <= {v, c, p};
    do @(posedge i_clk_sys); while (i_sample_ready !== 1'b1);
    o_sample_valid <= 1'b0;
    {o_volt, o_curr, o_pot} <= ~{v, c, p};
  endtask
endmodule

// file: test_analog_frequency_reference_scaler.sv
// Self-checking bench for the analog frequency reference scaler
`timescale 1ns/1ns
module test_analog_frequency_reference_scaler;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, sel = 0, frc = 0, set2 = 0, full_seen = 0;
  logic [3:0] adr = 4'h0, be = 4'hF;
  logic [31:0] wdat = 32'h0000_0000, q, x = 32'h0000_0055;
  logic [11:0] other = 12'h000, fc;
  logic [31:0] rdat;
  logic [9:0] vs, cs, ps, vc;
  logic wait_rq, s_rdy, s_val, f_val, m_set, an_out;
  logic [23:0] exp_q[$];
  int bad_count = 0, check_count = 0, v;

  always #2 clk = ~clk;

  analog_frequency_reference_scaler analog_frequency_reference_scaler_inst (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
    .i_sample_valid(s_val), .o_sample_ready(s_rdy), .i_volt_sample(vs), .i_curr_sample(cs),
    .i_pot_sample(ps), .i_input_selector_terminal(sel), .i_terminal_force(frc), .i_set2_select(set2),
    .i_other_freq(other), .o_freq_cmd(fc), .o_volt_cmd(vc), .o_freq_valid(f_val), .o_motor_set(m_set),
    .o_ref_is_analog(an_out));

  sample_source sample_source_inst (
    .i_clk_sys(clk), .i_sample_ready(s_rdy), .o_sample_valid(s_val), .o_volt(vs), .o_curr(cs), .o_pot(ps));

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] sw(input logic [7:0] s, input logic [1:0] i, vb, cb, input logic [3:0] a);
    return {4'h0, a, 6'h00, cb, 2'h0, vb, 2'h0, i, s};
  endfunction

  // Expected word: set, analog flag, frequency, voltage
  function automatic logic [23:0] ex(input logic s, an, input int f, b);
    return {s, an, f[11:0], (f >= b) ? 10'h3E8 : 10'(f * 1000 / b)};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_rq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk("register", q, e);
  endtask

  task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1, a, d);
    rchk(a, e);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) chk("pending results", exp_q.size(), 0);
    repeat (2) @(posedge clk);
  endtask

  task automatic cfg(input logic [31:0] d);
    drain();
    wchk(4'h0, d, d);
  endtask

  task automatic smp(input int v, c, p, f, input logic s = 0, an = 1, input int b = 2000);
    exp_q.push_back(ex(s, an, f, b));
    sample_source_inst.send(10'(v), 10'(c), 10'(p), int'(rnd() % 3));
  endtask

  always @(posedge clk) begin
    if (s_rdy === 1'b0) full_seen <= 1'b1;
    if (f_val === 1'b1) begin
      if (exp_q.size() == 0) chk("spurious output", 0, 1);
      else chk("output", {m_set, an_out, fc, vc}, exp_q.pop_front());
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(4'h0, sw(1, 0, 1, 1, 2));
    rchk(4'h1, 32'h0000_01F4);
    rchk(4'h6, 32'h0000_0000);
    rchk(4'h7, 32'h0000_6400);
    wchk(4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
    wchk(4'h2, 4001, 500);
    wchk(4'h1, 299, 500);
    wchk(4'h1, 501, 500);
    wchk(4'h2, 4000, 4000);
    wchk(4'h1, 2000, 2000);
    wchk(4'h2, 1999, 4000);
    wchk(4'h4, 499, 500);
    wchk(4'h3, 299, 500);
    wchk(4'h5, 4001, 0);
    wchk(4'h7, 32'h0000_6514, 32'h0000_6414);
    be <= 4'h1;
    wchk(4'h7, 32'h0000_0005, 32'h0000_6405);
    be <= 4'hF;
    wchk(4'h5, 100, 100);
    wchk(4'h6, 1000, 1000);
    wchk(4'h7, 32'h0000_5014, 32'h0000_5014);
    wchk(4'h8, 50, 50);
    wchk(4'h9, 450, 450);
    wchk(4'hA, 32'h0000_5A32, 32'h0000_5A32);
    cfg(sw(1, 0, 0, 1, 2));
    smp(600, 0, 0, 250);
    smp(600, 0, 0, 700);
    cfg(sw(1, 0, 0, 1, 1));
    smp(500, 0, 0, 550);
    smp(900, 0, 0, 1000);
    smp(100, 0, 0, 100);
    repeat (20) begin
      v = 200 + 2 * int'(rnd() % 301);
      smp(v, int'(rnd() % 1001), int'(rnd() % 1001), 100 + (v - 200) * 3 / 2);
    end
    drain();
    chk("ready low", full_seen, 1'b1);
    sel <= 1'b1;
    smp(0, 700, 0, 250);
    smp(0, 950, 0, 450);
    smp(0, 100, 0, 0);
    cfg(sw(1, 0, 0, 0, 1));
    smp(0, 100, 0, 50);
    cfg(sw(1, 1, 0, 0, 1));
    smp(500, 700, 0, 800);
    cfg(sw(1, 2, 0, 0, 1));
    smp(0, 0, 500, 550);
    cfg(sw(1, 3, 0, 0, 1));
    sel <= 1'b0;
    smp(0, 700, 0, 250);
    cfg(sw(2, 3, 0, 0, 1));
    other <= 12'h07B;
    smp(0, 700, 0, 123, 0, 0);
    drain();
    frc <= 1'b1;
    smp(0, 700, 0, 250);
    cfg(sw(2, 0, 0, 0, 1));
    set2 <= 1'b1;
    smp(900, 0, 0, 500, 1, 1, 500);
    drain();
    print_verdict();
  end
endmodule
